//--- hw/amcs_top.v
// alert masking, conversion rate and one-shot scheduling register bank
`timescale 1ns/10ps
`default_nettype none
`include "amcs_consts.vh"
module amcs_top
#(
    parameter [31:0] FAST_PERIOD = `AMCS_FAST_PERIOD_CYC
)
(
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // register access port
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    // latched alarm levels from the status logic
    input wire i_local_high_alarm,
    input wire i_remote_high_alarm,
    input wire i_remote_low_alarm,
    input wire i_remote_crit_alarm,
    input wire i_fan_speed_alarm,
    input wire i_diode_fault_alarm,
    // mode
    input wire i_idle,
    input wire i_pin_is_fan_input,
    // measurement engine handshake
    input wire i_conv_done,
    output reg o_conv_start,
    output reg o_conv_busy,
    // alert and rate
    output reg o_alert,
    output reg [7:0] o_rate_code
);

    // ------------------------------------------------------------------------
    // state machine for conversions
    // ------------------------------------------------------------------------
    // one-hot pair: waiting for a request, or a conversion in flight
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;

    // registers and internal nets
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] mask_q;
    reg [7:0] rate_q;
    wire tick;
    wire rate_hit;
    wire oneshot_hit;
    wire start_req;
    wire [7:0] alarm_vec;
    wire [7:0] gated_vec;
    wire [7:0] status_rd;
    wire [7:0] mask_rd;

    // codes 0..9 map to a shift of 9-code over the 32 Hz period;
    // code 5 taken as 2 Hz and code 8 as 16 Hz
    function [3:0] rate_shift;
        input [7:0] code;
        begin
            if (code <= `AMCS_RATE_FASTEST)
                rate_shift = 4'h9 - code[3:0];
            else
                rate_shift = 4'h0;
        end
    endfunction

    // address decode shared by reads and writes
    function is_rate;
        input [7:0] addr;
        begin
            is_rate = (addr == `AMCS_OFF_RATE) || (addr == `AMCS_OFF_RATE_ALIAS);
        end
    endfunction

    // both rate offsets land in the same register
    assign rate_hit = i_reg_wr && is_rate(i_reg_addr);
    // data value is irrelevant and non-idle writes fall away
    assign oneshot_hit = i_reg_wr && (i_reg_addr == `AMCS_OFF_ONESHOT) && i_idle;
    assign start_req = i_idle ? oneshot_hit : tick;

    // ------------------------------------------------------------------------
    // periodic scheduler, halted in low-power idle
    // ------------------------------------------------------------------------
    // while idle the counter is cleared, so the first periodic start after
    // idle comes one full period later, never at once
    amcs_conv_timer #(
        .FAST_PERIOD(FAST_PERIOD)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_run(~i_idle),
        .i_shift(rate_shift(rate_q)),
        .o_tick(tick)
    );

    // ------------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------------
    // mask keeps only the five event bits; the unused ones read back as 1
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rate_q <= `AMCS_RATE_RESET;
            mask_q <= `AMCS_MASK_RESET;
        end
        else
        begin
            if (rate_hit)
                rate_q <= i_reg_wdata;
            if (i_reg_wr && (i_reg_addr == `AMCS_OFF_MASK))
                mask_q <= i_reg_wdata & `AMCS_MASK_STORED;
        end
    end

    // ------------------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------------------
    // a start while a conversion runs is dropped, so one write gives one cycle
    always @*
    begin
        case (state_q)
            ST_WAIT:
                state_d = start_req ? ST_CONV : ST_WAIT;
            ST_CONV:
                state_d = i_conv_done ? ST_WAIT : ST_CONV;
            default:
                state_d = ST_WAIT;
        endcase
    end

    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ST_WAIT;
            o_conv_start <= 1'b0;
            o_conv_busy <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            o_conv_start <= (state_q == ST_WAIT) && start_req;
            o_conv_busy <= (state_d == ST_CONV);
        end
    end

    // ------------------------------------------------------------------------
    // alert gating
    // ------------------------------------------------------------------------
    // positions without an alerting event are tied low, so a stray mask
    // write can never let busy, diode fault or fan speed through
    assign alarm_vec[`AMCS_BIT_BUSY] = 1'b0;
    assign alarm_vec[`AMCS_BIT_LOCAL_HIGH] = i_local_high_alarm;
    assign alarm_vec[5] = 1'b0;
    assign alarm_vec[`AMCS_BIT_REMOTE_HIGH] = i_remote_high_alarm;
    assign alarm_vec[`AMCS_BIT_REMOTE_LOW] = i_remote_low_alarm;
    assign alarm_vec[`AMCS_BIT_DIODE_FAULT] = 1'b0;
    assign alarm_vec[`AMCS_BIT_REMOTE_CRIT] = i_remote_crit_alarm;
    assign alarm_vec[`AMCS_BIT_FAN_SPEED] = 1'b0;

    // each event reaches the alert only while its mask bit is clear
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_gate
            assign gated_vec[g] = alarm_vec[g] & ~mask_q[g];
        end
    endgenerate

    // when the shared pin senses the fan it cannot carry an alert at all
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            o_alert <= 1'b0;
        else
            o_alert <= (|gated_vec) & ~i_pin_is_fan_input;
    end

    // ------------------------------------------------------------------------
    // read path, one cycle after the read strobe
    // ------------------------------------------------------------------------
    // status is read live from the alarm inputs; clearing the latched alarms
    // belongs to the status logic outside this bank
    assign mask_rd = mask_q | `AMCS_MASK_ONES;
    assign status_rd = {o_conv_busy, i_local_high_alarm, 1'b0, i_remote_high_alarm,
                        i_remote_low_alarm, i_diode_fault_alarm, i_remote_crit_alarm,
                        i_fan_speed_alarm};

    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
            o_rate_code <= `AMCS_RATE_RESET;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            // follows a write one edge later, in step with the register itself
            o_rate_code <= rate_hit ? i_reg_wdata : rate_q;
            if (i_reg_rd)
            begin
                if (is_rate(i_reg_addr))
                    o_reg_rdata <= rate_q;
                else if (i_reg_addr == `AMCS_OFF_MASK)
                    o_reg_rdata <= mask_rd;
                else if (i_reg_addr == `AMCS_OFF_STATUS)
                    o_reg_rdata <= status_rd;
                else
                    o_reg_rdata <= 8'h00; // one-shot is write-only, unmapped reads zero
            end
        end
    end

endmodule // amcs_top
`default_nettype wire

//--- hw/amcs_consts.vh
// constants for the alert mask and conversion scheduling register bank
`ifndef AMCS_CONSTS_VH
`define AMCS_CONSTS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define AMCS_OFF_STATUS 8'h02
`define AMCS_OFF_RATE 8'h04
`define AMCS_OFF_RATE_ALIAS 8'h0A
`define AMCS_OFF_ONESHOT 8'h0F
`define AMCS_OFF_MASK 8'h16

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define AMCS_BIT_BUSY 7
`define AMCS_BIT_LOCAL_HIGH 6
`define AMCS_BIT_REMOTE_HIGH 4
`define AMCS_BIT_REMOTE_LOW 3
`define AMCS_BIT_DIODE_FAULT 2
`define AMCS_BIT_REMOTE_CRIT 1
`define AMCS_BIT_FAN_SPEED 0

// ----------------------------------------------------------------------------
// reset values and fixed bits
// ----------------------------------------------------------------------------
`define AMCS_RATE_RESET 8'h08
`define AMCS_MASK_RESET 8'h00
`define AMCS_MASK_ONES 8'hA4
`define AMCS_MASK_STORED 8'h5B
`define AMCS_RATE_FASTEST 8'h09

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define AMCS_CLK_PERIOD_NS 40
`define AMCS_FAST_PERIOD_NS 31250000
`define AMCS_FAST_PERIOD_CYC (`AMCS_FAST_PERIOD_NS / `AMCS_CLK_PERIOD_NS)

`endif

//--- hw/amcs_conv_timer.v
// periodic conversion tick generator for the selected conversion rate
`timescale 1ns/10ps
`default_nettype none
module amcs_conv_timer
#(
    parameter [31:0] FAST_PERIOD = 32'd781250
)
(
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // control
    input wire i_run,
    input wire [3:0] i_shift,
    // tick
    output reg o_tick
);

    reg [31:0] cnt_q;
    wire [31:0] period;

    // slowest code shifts by 9, which still fits 32 bits
    assign period = FAST_PERIOD << i_shift;

    // compare with >= so a shorter rate takes effect without waiting out the old one
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 32'h0000_0000;
            o_tick <= 1'b0;
        end
        else if (!i_run)
        begin
            cnt_q <= 32'h0000_0000;
            o_tick <= 1'b0;
        end
        else if (cnt_q >= period - 32'h0000_0001)
        begin
            cnt_q <= 32'h0000_0000;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h0000_0001;
            o_tick <= 1'b0;
        end
    end

endmodule // amcs_conv_timer
`default_nettype wire

//--- tb/amcs_host_model.sv
// register host model driving the strobe port of the bank
`timescale 1ns/10ps
`default_nettype none
module amcs_host_model
(
    // clock and strobe port
    input wire logic i_mclk,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    // one strobe edge per byte; released lines show the inverse, never a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    // read data is taken once the answering edge has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule // amcs_host_model
`default_nettype wire

//--- tb/amcs_monitor.sv
// assertions on the ports of the register bank
`timescale 1ns/10ps
`default_nettype none
module amcs_monitor
(
    // clock, reset, register port (grouped to save space)
    input wire logic i_mclk, i_rst, i_reg_wr, i_reg_rd,
    input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_rate_code,
    // alarms, mode, conversion and alert
    input wire logic i_local_high_alarm, i_remote_high_alarm, i_remote_low_alarm,
    input wire logic i_remote_crit_alarm, i_idle, i_pin_is_fan_input, i_conv_done,
    input wire logic o_conv_start, o_conv_busy, o_alert
);
    logic [7:0] mask_q;
    logic hot;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // mask shadow, so alert is judged from port traffic alone
    always @(posedge i_mclk or posedge i_rst)
        if (i_rst)
            mask_q <= 8'h00;
        else if (i_reg_wr && i_reg_addr == 8'h16)
            mask_q <= i_reg_wdata;
    // unmasked alarm able to reach the pin; fan pin mode silences all
    assign hot = !i_pin_is_fan_input && |({i_local_high_alarm, i_remote_high_alarm,
        i_remote_low_alarm, i_remote_crit_alarm} & ~{mask_q[6], mask_q[4], mask_q[3], mask_q[1]});
    a_alert_raised: assert property (hot |=> o_alert)
        else $error("alert missing");
    a_alert_quiet: assert property (!hot |=> !o_alert)
        else $error("alert without cause");
    a_mask_ones: assert property (i_reg_rd && i_reg_addr == 8'h16
        |=> o_reg_rdata[7] && o_reg_rdata[5] && o_reg_rdata[2]) else $error("mask bit low");
    a_rate_write: assert property (i_reg_wr && i_reg_addr == 8'h04
        |=> o_rate_code == $past(i_reg_wdata)) else $error("rate not written");
    a_oneshot_start: assert property (i_reg_wr && i_reg_addr == 8'h0F && i_idle && !o_conv_busy
        |=> o_conv_start && o_conv_busy) else $error("one-shot lost");
    a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start too long");
    a_busy_refuse: assert property (o_conv_busy && !i_conv_done |=> !o_conv_start)
        else $error("start while busy");
    a_busy_clear: assert property (o_conv_busy && i_conv_done |=> !o_conv_busy)
        else $error("busy stuck");
    c_alert: cover property (o_alert);
    c_oneshot: cover property (i_idle && o_conv_start);
    c_timer: cover property (!i_idle && o_conv_start);
endmodule // amcs_monitor
bind amcs_top amcs_monitor amcs_monitor_i (.i_mclk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_rate_code, .i_local_high_alarm, .i_remote_high_alarm,
    .i_remote_low_alarm, .i_remote_crit_alarm, .i_idle, .i_pin_is_fan_input, .i_conv_done,
    .o_conv_start, .o_conv_busy, .o_alert);
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the alert mask and conversion scheduling bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic i_mclk = 1'b0, i_rst = 1'b1, idle = 1'b0, fan = 1'b0, done = 1'b0, auto = 1'b1;
    logic [7:0] a, wd, rdat, rate;
    logic w, r, rv, start, busy, alert;
    logic [5:0] al = 6'h00;
    int miscompares = 0, compares = 0, cycles = 0;
    amcs_top #(.FAST_PERIOD(32'd8)) amcs_top_i (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_reg_addr(a), .i_reg_wdata(wd), .i_reg_wr(w), .i_reg_rd(r), .o_reg_rdata(rdat),
        .o_reg_rvalid(rv), .i_local_high_alarm(al[5]), .i_remote_high_alarm(al[4]),
        .i_remote_low_alarm(al[3]), .i_remote_crit_alarm(al[2]), .i_fan_speed_alarm(al[1]),
        .i_diode_fault_alarm(al[0]), .i_idle(idle), .i_pin_is_fan_input(fan),
        .i_conv_done(done), .o_conv_start(start), .o_conv_busy(busy), .o_alert(alert),
        .o_rate_code(rate));
    amcs_host_model amcs_host_model_i (.i_mclk(i_mclk), .o_addr(a), .o_wdata(wd),
        .o_wr(w), .o_rd(r), .i_rdata(rdat), .i_rvalid(rv));
    // clock, watchdog, and an engine that finishes at once while auto is set
    always #20 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        if (auto)
            done <= start;
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: want %h got %h", $time, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        amcs_host_model_i.rd(ad, d, v);
        chk({8'h01, e}, {7'h00, v, d});
    endtask
    task automatic t_reset();
        chk(8'h08, rate);
        rdchk(8'h0A, 8'h08);
        rdchk(8'h16, 8'hA4);
        rdchk(8'h0F, 8'h00);
    endtask
    // each alarm alone, unmasked then masked; then fan pin mode with all alarms up
    task automatic t_mask();
        amcs_host_model_i.wr(8'h16, 8'hFF);
        rdchk(8'h16, 8'hFF);
        for (int m = 0; m < 2; m++)
        begin
            amcs_host_model_i.wr(8'h16, m ? 8'h5B : 8'h00);
            for (int i = 0; i < 6; i++)
            begin
                @(posedge i_mclk);
                al <= 6'h20 >> i;
                repeat (3) @(posedge i_mclk);
                #1;
                chk(m == 0 && i < 4, alert);
            end
        end
        rdchk(8'h16, 8'hFF);
        amcs_host_model_i.wr(8'h16, 8'h00);
        al <= 6'h3F;
        fan <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        chk(1'b0, alert);
        @(posedge i_mclk);
        fan <= 1'b0;
        al <= 6'h00;
    endtask
    // interval between timer starts per code; first pass writes through the alias
    task automatic t_rate();
        logic [7:0] c [5] = '{8'h09, 8'h08, 8'h05, 8'h0C, 8'h00};
        int p [5] = '{8, 16, 128, 8, 4096};
        int n;
        for (int k = 0; k < 5; k++)
        begin
            @(posedge i_mclk);
            idle <= 1'b1;
            amcs_host_model_i.wr(k ? 8'h04 : 8'h0A, c[k]);
            rdchk(8'h04, c[k]);
            @(posedge i_mclk);
            idle <= 1'b0;
            for (int j = 0; j < 2; j++)
            begin
                n = 0;
                do
                begin
                    @(posedge i_mclk);
                    #1;
                    n++;
                end
                while (start !== 1'b1 && n < 9000);
            end
            chk(p[k], n);
        end
    endtask
    // one-shot in idle, a second write while busy is dropped, ignored when not idle
    task automatic t_oneshot();
        @(posedge i_mclk);
        idle <= 1'b1;
        auto <= 1'b0;
        repeat (2) @(posedge i_mclk);
        // the engine model has stopped; drop the done it may have left raised
        done <= 1'b0;
        amcs_host_model_i.wr(8'h0F, 8'h5A);
        #1;
        chk(2'b11, {start, busy});
        amcs_host_model_i.wr(8'h0F, 8'h00);
        #1;
        chk(3'b010, {start, busy, alert});
        rdchk(8'h02, 8'h80);
        @(posedge i_mclk);
        done <= 1'b1;
        @(posedge i_mclk);
        done <= 1'b0;
        idle <= 1'b0;
        #1;
        chk(2'b00, {start, busy});
        rdchk(8'h02, 8'h00);
        amcs_host_model_i.wr(8'h0F, 8'h00);
        #1;
        chk(2'b00, {start, busy});
    endtask
    initial
    begin
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_reset();
        t_mask();
        t_rate();
        t_oneshot();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
